// ===== hw/psr_read_path.sv
// pipelined burst sram front end: registered inputs, burst, selects, output control
`timescale 1ns/1ps
module psr_read_path
(
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        reset_i,
  // address and strobes
  input  wire logic [psr_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic                        cpu_addr_strobe_n_i,
  input  wire logic                        ctrl_addr_strobe_n_i,
  input  wire logic                        burst_step_n_i,
  // chip selects
  input  wire logic                        sel_first_n_i,
  input  wire logic                        sel_second_i,
  input  wire logic                        sel_third_n_i,
  // write controls
  input  wire logic                        all_byte_write_n_i,
  input  wire logic                        byte_write_gate_n_i,
  input  wire logic [psr_pkg::LANES-1:0]   lane_write_sel_n_i,
  // strap and output enable
  input  wire logic                        burst_order_i,
  input  wire logic                        out_enable_n_i,
  // data pins
  input  wire logic [psr_pkg::DATA_W-1:0]  dq_i,
  output logic      [psr_pkg::DATA_W-1:0]  dq_o,
  output logic                             dq_oe_o
);

  // ***********************************************
  // input registers
  // ***********************************************
  logic [psr_pkg::ADDR_W-1:0]  addr_q;
  logic                        cpu_q;
  logic                        ctrl_q;
  logic                        step_q;
  logic                        sel1_q;
  logic                        sel2_q;
  logic                        sel3_q;
  logic                        gw_q;
  logic                        bwe_q;
  logic [psr_pkg::LANES-1:0]   bw_q;
  logic [psr_pkg::DATA_W-1:0]  din_q;
  logic                        order_meta;
  logic                        order_q;
  logic                        oe_meta;
  logic                        oe_q;
  logic                        active;

  // capture all synchronous pins on the rising edge; strap and enable through two flops
  always_ff @(posedge clock_i)
  begin
    addr_q     <= addr_i;
    cpu_q      <= ~cpu_addr_strobe_n_i;
    ctrl_q     <= ~ctrl_addr_strobe_n_i;
    step_q     <= ~burst_step_n_i;
    sel1_q     <= ~sel_first_n_i;
    sel2_q     <= sel_second_i;
    sel3_q     <= ~sel_third_n_i;
    gw_q       <= ~all_byte_write_n_i;
    bwe_q      <= ~byte_write_gate_n_i;
    bw_q       <= ~lane_write_sel_n_i;
    din_q      <= dq_i;
    order_meta <= burst_order_i;
    order_q    <= order_meta;
    oe_meta    <= ~out_enable_n_i;
    oe_q       <= oe_meta;
  end

  // ***********************************************
  // cycle decode
  // ***********************************************
  wire cpu_take    = cpu_q & sel1_q;
  wire ctrl_take   = ctrl_q & ~cpu_take;
  wire new_addr    = cpu_take | ctrl_take;
  wire selected    = sel1_q & sel2_q & sel3_q;
  wire write_any   = gw_q | bwe_q;
  wire read_start  = new_addr & selected & ~write_any;
  wire write_start = ctrl_take & selected & write_any;
  wire deselect    = new_addr & ~selected;
  wire burst_cyc   = ~new_addr & active;
  wire step        = burst_cyc & step_q;
  wire linear      = ~order_q;

  // byte lane qualification with global override
  wire [psr_pkg::LANES-1:0] lane_we =
    gw_q ? psr_pkg::LANES_ALL : (bwe_q ? bw_q : psr_pkg::LANES_NONE);

  // ***********************************************
  // burst counter and address
  // ***********************************************
  logic [psr_pkg::ADDR_W-1:0]  base;
  logic [psr_pkg::BURST_W-1:0] burst_addr;
  logic                        active_rd;
  logic                        was_desel;
  logic                        first_mask;

  psr_burst_ctr u_burst
  (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .load_i   (new_addr),
    .step_i   (step),
    .linear_i (linear),
    .seed_i   (addr_q[psr_pkg::BURST_LSB +: psr_pkg::BURST_W]),
    .addr_o   (burst_addr)
  );

  // array address: fresh address at a start, burst address otherwise
  wire [psr_pkg::ADDR_W-1:0] arr_addr = new_addr ? addr_q
    : {base[psr_pkg::ADDR_W-1:psr_pkg::BURST_W], burst_addr};
  wire do_read = read_start | (burst_cyc & active_rd);

  // base address register and access state
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      base       <= psr_pkg::ADDR_ZERO;
      active     <= 1'b0;
      active_rd  <= 1'b0;
      was_desel  <= 1'b1;
      first_mask <= 1'b0;
    end
    else if (new_addr)
    begin
      base       <= addr_q;
      active     <= selected;
      active_rd  <= read_start;
      was_desel  <= ~selected;
      first_mask <= read_start & was_desel;
    end
    else
      first_mask <= 1'b0;
  end

  // ***********************************************
  // memory array and output registers
  // ***********************************************
  logic [psr_pkg::DATA_W-1:0] mem [psr_pkg::DEPTH];
  logic [psr_pkg::DATA_W-1:0] dout;
  logic                       dvalid;

  // lane writes land in the array from the registered data
  always_ff @(posedge clock_i)
  begin
    for (int l = 0; l < psr_pkg::LANES; l++)
      if ((write_start | (burst_cyc & ~active_rd & active)) && lane_we[l])
        mem[arr_addr][l*psr_pkg::BYTE_W +: psr_pkg::BYTE_W] <=
          din_q[l*psr_pkg::BYTE_W +: psr_pkg::BYTE_W];
  end

  // output register loads the array word for the read cycle
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      dout   <= psr_pkg::DATA_ZERO;
      dvalid <= 1'b0;
    end
    else
    begin
      if (do_read)
        dout <= mem[arr_addr];
      dvalid <= do_read & ~deselect;
    end
  end

  // drive only valid read data, masked on the first cycle out of deselect
  assign dq_o    = dout;
  assign dq_oe_o = dvalid & ~first_mask & oe_q & ~write_any;

  // ***********************************************
  // checks
  // ***********************************************
  a_deselect_off: assert property (@(posedge clock_i) disable iff (reset_i)
    deselect |=> !dq_oe_o)
    else $error("outputs driven after deselect");

  a_first_mask: assert property (@(posedge clock_i) disable iff (reset_i)
    (read_start && was_desel) |=> !dq_oe_o)
    else $error("outputs driven in first cycle out of deselect");

  a_read_data: assert property (@(posedge clock_i) disable iff (reset_i)
    read_start |=> (dout == $past(mem[arr_addr])))
    else $error("read data not loaded at next edge");

  a_hold_burst: assert property (@(posedge clock_i) disable iff (reset_i)
    (burst_cyc && !step_q) |->
      (burst_addr == $past(arr_addr[psr_pkg::BURST_LSB +: psr_pkg::BURST_W])))
    else $error("burst address moved without step");

  a_cpu_priority: assert property (@(posedge clock_i) disable iff (reset_i)
    (cpu_q && ctrl_q && sel1_q) |-> (cpu_take && !ctrl_take))
    else $error("controller strobe won over processor strobe");

  a_cpu_ignored: assert property (@(posedge clock_i) disable iff (reset_i)
    (!sel1_q && !ctrl_q) |-> !new_addr)
    else $error("processor strobe honoured with first select off");

  a_linear_step: assert property (@(posedge clock_i) disable iff (reset_i)
    (step && linear) |->
      (burst_addr == $past(arr_addr[psr_pkg::BURST_LSB +: psr_pkg::BURST_W]) + psr_pkg::BURST_ONE))
    else $error("linear burst did not count up");

  a_global_write: assert property (@(posedge clock_i) disable iff (reset_i)
    gw_q |-> (lane_we == psr_pkg::LANES_ALL))
    else $error("global write missed a lane");

endmodule : psr_read_path

// ===== hw/psr_pkg.sv
// package of constants for the pipelined burst sram read path
package psr_pkg;

  // ***********************************************
  // widths
  // ***********************************************
  localparam int ADDR_W  = 10;                 // array address width (model depth)
  localparam int LANES   = 4;                  // byte lanes
  localparam int BYTE_W  = 9;                  // data plus parity bit per lane
  localparam int DATA_W  = LANES * BYTE_W;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int BURST_W = 2;                  // wraparound burst counter width

  // ***********************************************
  // field positions and constants
  // ***********************************************
  localparam int                 BURST_LSB   = 0;
  localparam logic [BURST_W-1:0] BURST_ONE   = 2'h1;
  localparam logic [BURST_W-1:0] BURST_ZERO  = 2'h0;
  localparam logic [ADDR_W-1:0]  ADDR_ZERO   = 10'h000;
  localparam logic [DATA_W-1:0]  DATA_ZERO   = 36'h0_0000_0000;
  localparam logic [LANES-1:0]   LANES_ALL   = 4'hf;
  localparam logic [LANES-1:0]   LANES_NONE  = 4'h0;

  // ***********************************************
  // timing
  // ***********************************************
  localparam real CLK_PERIOD_NS       = 5.0;
  localparam real CLK_TO_OUT_TIME_NS  = 3.0;   // longest clock-to-output time
  localparam int  CLK_TO_OUT_CYCLES   =
    (int'(CLK_TO_OUT_TIME_NS / CLK_PERIOD_NS) < 1) ? 1
                                                  : int'(CLK_TO_OUT_TIME_NS / CLK_PERIOD_NS);

endpackage : psr_pkg

// ===== hw/psr_burst_ctr.sv
// two-bit wraparound burst counter with linear or interleaved order
`timescale 1ns/1ps
module psr_burst_ctr
(
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        reset_i,
  // control
  input  wire logic                        load_i,
  input  wire logic                        step_i,
  input  wire logic                        linear_i,
  input  wire logic [psr_pkg::BURST_W-1:0] seed_i,
  // burst address
  output logic      [psr_pkg::BURST_W-1:0] addr_o
);

  logic [psr_pkg::BURST_W-1:0] seed;
  logic [psr_pkg::BURST_W-1:0] count;
  logic [psr_pkg::BURST_W-1:0] stepped;
  logic [psr_pkg::BURST_W-1:0] next_count;

  // a stepping cycle already uses the next offset, so access and step agree
  assign stepped    = step_i ? count + psr_pkg::BURST_ONE : count;
  assign next_count = load_i ? psr_pkg::BURST_ZERO : stepped;

  // linear adds, interleaved exclusive-ors the seed with the offset in use
  assign addr_o = linear_i ? seed + stepped : seed ^ stepped;

  // seed and count registers
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      seed  <= psr_pkg::BURST_ZERO;
      count <= psr_pkg::BURST_ZERO;
    end
    else
    begin
      if (load_i)
        seed <= seed_i;
      count <= next_count;
    end
  end

endmodule : psr_burst_ctr

// ===== verification/psr_host_model.sv
// far-side model: shared data lines and burst order strap seen by the sram
`timescale 1ns/1ps
module psr_host_model
(
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        reset_i,
  // host side
  input  wire logic                        order_sel_i,
  input  wire logic                        host_drive_i,
  input  wire logic [psr_pkg::DATA_W-1:0]  host_data_i,
  // sram side
  input  wire logic [psr_pkg::DATA_W-1:0]  sram_dq_i,
  input  wire logic                        sram_oe_i,
  output logic      [psr_pkg::DATA_W-1:0]  bus_o,
  output logic                             burst_order_o
);
  logic [psr_pkg::DATA_W-1:0] last_bus;

  // strap only follows the host while in reset, so it stays static in operation
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      burst_order_o <= order_sel_i;
  end

  // remember the bus so an undriven bus can show its inverse, never a stale copy
  always_ff @(posedge clock_i)
  begin
    last_bus <= bus_o;
  end

  // wire resolution: sram, then host, else a floating pattern
  assign bus_o = sram_oe_i ? sram_dq_i : (host_drive_i ? host_data_i : ~last_bus);
endmodule : psr_host_model

// ===== verification/tb_top.sv
// self-checking testbench for the pipelined burst sram read path
`timescale 1ns/1ps
module tb_top;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [9:0]  addr = 10'h000;
  logic        ps_n = 1'b1, cs_n = 1'b1, step_n = 1'b1, s1_n = 1'b1, gw_n = 1'b1;
  logic        bwe_n = 1'b1, order_sel = 1'b0, host_drive = 1'b0;
  logic        sel2 = 1'b1, oe_n = 1'b0;
  logic [3:0]  lanes_n = 4'hf;
  logic [35:0] host_data = 36'h0_0000_0000, dq_i, dq_o, exp_mem [0:1023];
  logic        dq_oe, burst_order;
  int          error_cnt = 0, cmp_count = 0;

  // 200 MHz clock
  always #2.5 clock_i = ~clock_i;

  psr_read_path psr_read_path_inst (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr),
    .cpu_addr_strobe_n_i(ps_n), .ctrl_addr_strobe_n_i(cs_n), .burst_step_n_i(step_n),
    .sel_first_n_i(s1_n), .sel_second_i(sel2), .sel_third_n_i(1'b0),
    .all_byte_write_n_i(gw_n), .byte_write_gate_n_i(bwe_n), .lane_write_sel_n_i(lanes_n),
    .burst_order_i(burst_order), .out_enable_n_i(oe_n), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe));
  psr_host_model psr_host_model_inst (.clock_i(clock_i), .reset_i(reset_i),
    .order_sel_i(order_sel), .host_drive_i(host_drive), .host_data_i(host_data),
    .sram_dq_i(dq_o), .sram_oe_i(dq_oe), .bus_o(dq_i), .burst_order_o(burst_order));

  task check(input string name, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : check

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // one bus cycle at the falling edge; wr 1 global write, 2 lane zero write
  // desel bit 0 turns the first select off, bit 1 the second
  task cyc(input logic ps, cs, st, input int wr, input logic [1:0] desel,
           input logic [9:0] a, input logic [35:0] d);
    @(negedge clock_i);
    ps_n = ps;
    cs_n = cs;
    step_n = st;
    s1_n = desel[0];
    sel2 = ~desel[1];
    addr = a;
    gw_n = (wr != 1);
    bwe_n = (wr != 2);
    lanes_n = (wr == 2) ? 4'he : 4'hf;
    host_drive = (wr != 0);
    host_data = d;
  endtask : cyc

  task do_reset(input logic order);
    order_sel = order;
    reset_i = 1'b1;
    repeat (10) @(negedge clock_i);
    reset_i = 1'b0;
    repeat (2) @(negedge clock_i);
    for (int i = 0; i < 4; i++)
    begin
      exp_mem[10'h100 + i] = {26'h2a5_0000, 10'h100 + 10'(i)};
      cyc(1, 0, 1, 1, 0, 10'h100 + 10'(i), exp_mem[10'h100 + i]);
    end
  endtask : do_reset

  // lane write, deselect, then back-to-back reads coming out of deselect
  task t_reads;
    exp_mem[10'h101][8:0] = 9'h1_5a;
    cyc(1, 0, 1, 2, 0, 10'h101, 36'hf_ffff_fd5a);
    cyc(0, 0, 1, 0, 1, 10'h000, 36'h0_0000_0000);
    cyc(1, 0, 1, 0, 0, 10'h101, 36'h0_0000_0000);
    cyc(0, 1, 1, 0, 0, 10'h102, 36'h0_0000_0000);
    check("deselect oe", 36'h0, {35'h0, dq_oe});
    cyc(1, 0, 1, 0, 1, 10'h000, 36'h0_0000_0000);
    check("first read data", exp_mem[10'h101], dq_o);
    check("first read oe", 36'h0, {35'h0, dq_oe});
    cyc(1, 1, 1, 0, 0, 10'h000, 36'h0_0000_0000);
    check("second read data", exp_mem[10'h102], dq_o);
    check("second read oe", 36'h1, {35'h0, dq_oe});
    cyc(1, 1, 1, 0, 0, 10'h000, 36'h0_0000_0000);
    check("deselect after read oe", 36'h0, {35'h0, dq_oe});
  endtask : t_reads

  // second select off deselects; a high output enable keeps read data off the bus
  task t_selects;
    cyc(0, 1, 1, 0, 2, 10'h000, 36'h0_0000_0000);
    cyc(0, 1, 1, 0, 0, 10'h100, 36'h0_0000_0000);
    cyc(1, 0, 1, 0, 0, 10'h101, 36'h0_0000_0000);
    cyc(1, 0, 1, 0, 0, 10'h102, 36'h0_0000_0000);
    check("reselect data", exp_mem[10'h100], dq_o);
    check("reselect oe", 36'h0, {35'h0, dq_oe});
    oe_n = 1'b1;
    cyc(1, 1, 1, 0, 0, 10'h000, 36'h0_0000_0000);
    check("enabled read data", exp_mem[10'h101], dq_o);
    check("enabled read oe", 36'h1, {35'h0, dq_oe});
    cyc(1, 1, 1, 0, 0, 10'h000, 36'h0_0000_0000);
    check("disabled read data", exp_mem[10'h102], dq_o);
    check("disabled read oe", 36'h0, {35'h0, dq_oe});
    oe_n = 1'b0;
  endtask : t_selects

  // burst from a processor strobe; st bits 1 to 3 ask for a step in that beat
  task t_burst(input logic [9:0] a, input logic [3:0] st, input logic lin);
    logic [1:0]  cnt, off;
    logic [35:0] e [0:3];
    cnt = 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (k > 0 && st[k])
        cnt = cnt + 2'h1;
      off = lin ? a[1:0] + cnt : a[1:0] ^ cnt;
      e[k] = exp_mem[{a[9:2], off}];
    end
    cyc(0, 1, 1, 0, 0, a, 36'h0_0000_0000);
    for (int j = 1; j < 6; j++)
    begin
      cyc(1, 1, (j < 4) ? !st[j] : 1'b1, 0, 0, 10'h000, 36'h0_0000_0000);
      if (j >= 2)
        check("burst data", e[j-2], dq_o);
      if (j >= 3)
        check("burst oe", 36'h1, {35'h0, dq_oe});
    end
  endtask : t_burst

  // watchdog against a hung run
  initial
  begin
    #100000;
    error_cnt++;
    test_done();
  end

  // main sequence
  initial
  begin
    do_reset(1'b0);
    t_reads();
    t_selects();
    t_burst(10'h103, 4'hf, 1'b1);
    t_burst(10'h101, 4'ha, 1'b1);
    do_reset(1'b1);
    t_burst(10'h101, 4'hf, 1'b0);
    test_done();
  end
endmodule : tb_top
